/* dv/test_uec_ep0_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

module test_uec_ep0_ctrl
  import uec_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset, link_setup, link_out, link_in_token, link_tx_done, fw_csr_we, fw_addr_we;
  logic fw_int_ack, ep0_int_en, rx_packet_ready, tx_packet_ready, stall_sent_flag;
  logic premature_end_flag, data_phase_end, stall_request, fifo_dir_in, hs_ack, hs_nak;
  logic hs_stall, tx_send, tx_zero_len, ep0_int;
  logic [6:0] link_len, fw_addr, ep0_rx_byte_count, function_address;
  logic [7:0] link_req_type, fw_csr_wdata;
  logic [15:0] link_req_length;
  logic [2:0] ep0_state;
  logic [3:0] ack_delay;
  int n_errors = 0;
  int n_checks = 0;
  // Rows: request type, length, control write, state, fifo direction
  localparam logic [35:0] ROWS [4] = '{{8'h00, 16'h0000, 8'h48, UEC_IDLE, 1'b0},
    {8'h80, 16'h0000, 8'h48, UEC_IDLE, 1'b0}, {8'h00, 16'h0046, 8'h40, UEC_RX, 1'b0},
    {8'h80, 16'h0050, 8'h40, UEC_TX, 1'b1}};

  always #2 core_clk = ~core_clk;

  uec_ep0_ctrl uec_ep0_ctrl_i (.core_clk(core_clk), .reset(reset), .link_setup(link_setup),
    .link_out(link_out), .link_len(link_len), .link_req_type(link_req_type),
    .link_req_length(link_req_length), .link_in_token(link_in_token),
    .link_tx_done(link_tx_done), .fw_csr_we(fw_csr_we), .fw_csr_wdata(fw_csr_wdata),
    .fw_addr_we(fw_addr_we), .fw_addr(fw_addr), .fw_int_ack(fw_int_ack),
    .ep0_int_en(ep0_int_en), .rx_packet_ready(rx_packet_ready),
    .tx_packet_ready(tx_packet_ready), .stall_sent_flag(stall_sent_flag),
    .premature_end_flag(premature_end_flag), .data_phase_end(data_phase_end),
    .stall_request(stall_request), .ep0_rx_byte_count(ep0_rx_byte_count),
    .function_address(function_address), .ep0_state(ep0_state), .fifo_dir_in(fifo_dir_in),
    .hs_ack(hs_ack), .hs_nak(hs_nak), .hs_stall(hs_stall), .tx_send(tx_send),
    .tx_zero_len(tx_zero_len), .ep0_int(ep0_int));

  uec_host_model uec_host_model_i (.core_clk(core_clk), .tx_send(tx_send),
    .ack_delay(ack_delay), .link_setup(link_setup), .link_out(link_out),
    .link_in_token(link_in_token), .link_tx_done(link_tx_done), .link_len(link_len),
    .link_req_type(link_req_type), .link_req_length(link_req_length));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tk(input logic [1:0] k, input logic [6:0] n, input logic [7:0] rt,
                    input logic [15:0] rl);
    uec_host_model_i.tok(k, n, rt, rl);
  endtask

  task automatic fw(input logic [7:0] v);
    @(negedge core_clk);
    fw_csr_we = 1'b1;
    fw_csr_wdata = v;
    @(negedge core_clk);
    fw_csr_we = 1'b0;
  endtask

  task automatic ack();
    @(negedge core_clk);
    fw_int_ack = 1'b1;
    @(negedge core_clk);
    fw_int_ack = 1'b0;
    chk("int_ack", 1'b0, ep0_int);
  endtask

  task automatic rst();
    @(negedge core_clk);
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
  endtask

  // Bound on the host's ack; a hang ends the run
  task automatic wait_tx();
    int i;
    for (i = 0; i < 20 && tx_packet_ready !== 1'b0; i++) @(negedge core_clk);
    if (i == 20) begin
      n_errors++;
      $display("Error tx_wait expected 0 seen 1");
      end_of_test();
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    {fw_csr_we, fw_addr_we, fw_int_ack} = 3'h0;
    fw_csr_wdata = 8'h00;
    fw_addr = 7'h00;
    ep0_int_en = 1'b1;
    ack_delay = 4'h0;
    repeat (12) @(negedge core_clk);
    chk("state_rst", UEC_IDLE, ep0_state);
    chk("flags_rst", 6'h00, {rx_packet_ready, tx_packet_ready, stall_sent_flag,
        premature_end_flag, data_phase_end, stall_request});
    reset = 1'b0;
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      rst();
      tk(2'h0, 7'h08, ROWS[r][35:28], ROWS[r][27:12]);
      chk("rx_ready", 1'b1, rx_packet_ready);
      fw(ROWS[r][11:4]);
      chk("rx_clear", 1'b0, rx_packet_ready);
      chk("state", ROWS[r][3:1], ep0_state);
      chk("fifo_dir", ROWS[r][0], fifo_dir_in);
      chk("data_end", ROWS[r][7], data_phase_end);
    end
    $display("test rows done");
    rst();
    tk(2'h0, 7'h08, 8'h00, 16'h0000);
    chk("hs_ack", 1'b1, hs_ack);
    chk("int", 1'b1, ep0_int);
    chk("count", 7'h08, ep0_rx_byte_count);
    @(negedge core_clk);
    fw_addr_we = 1'b1;
    fw_addr = 7'h5a;
    @(negedge core_clk);
    fw_addr_we = 1'b0;
    chk("function_address", 7'h5a, function_address);
    fw(8'h48);
    ack();
    tk(2'h2, 7'h00, 8'h00, 16'h0000);
    chk("zero_len", 1'b1, tx_zero_len);
    chk("int_done", 1'b1, ep0_int);
    tk(2'h0, 7'h07, 8'h00, 16'h0000);
    chk("short_setup", 2'h0, {hs_ack, rx_packet_ready});
    $display("test zero_data done");
    ep0_int_en = 1'b0;
    ack();
    tk(2'h0, 7'h08, 8'h00, 16'h0000);
    chk("int_masked", 1'b0, ep0_int);
    ep0_int_en = 1'b1;
    @(negedge core_clk);
    chk("int_unmask", 1'b1, ep0_int);
    fw(8'h60);
    chk("stall_req", 1'b1, stall_request);
    ack();
    tk(2'h2, 7'h00, 8'h00, 16'h0000);
    chk("stall", 3'h7, {hs_stall, stall_sent_flag, ep0_int});
    repeat (3) @(negedge core_clk);
    chk("stall_sticky", 1'b1, stall_sent_flag);
    fw(8'h04);
    chk("stall_clr", 1'b0, stall_sent_flag);
    $display("test stall done");
    tk(2'h0, 7'h08, 8'h00, 16'h0046);
    fw(8'h40);
    chk("state_rx", UEC_RX, ep0_state);
    tk(2'h1, 7'h40, 8'h00, 16'h0000);
    chk("out_full", 8'hc0, {rx_packet_ready, ep0_rx_byte_count});
    tk(2'h1, 7'h05, 8'h00, 16'h0000);
    chk("out_nak", 1'b1, hs_nak);
    fw(8'h40);
    tk(2'h1, 7'h06, 8'h00, 16'h0000);
    chk("out_short", 8'h86, {rx_packet_ready, ep0_rx_byte_count});
    fw(8'h48);
    ack();
    tk(2'h1, 7'h01, 8'h00, 16'h0000);
    chk("out_extra", 3'h7, {hs_stall, stall_sent_flag, ep0_int});
    chk("state_idle", UEC_IDLE, ep0_state);
    fw(8'h04);
    $display("test write done");
    tk(2'h0, 7'h08, 8'h80, 16'h0050);
    fw(8'h40);
    chk("state_tx", UEC_TX, ep0_state);
    tk(2'h2, 7'h00, 8'h00, 16'h0000);
    chk("in_nak", 1'b1, hs_nak);
    fw(8'h02);
    chk("tx_ready", 1'b1, tx_packet_ready);
    ack();
    tk(2'h2, 7'h00, 8'h00, 16'h0000);
    chk("tx_send", 1'b1, tx_send);
    wait_tx();
    chk("tx_int", 1'b1, ep0_int);
    chk("state_tx2", UEC_TX, ep0_state);
    ack_delay = 4'h5;
    fw(8'h0a);
    tk(2'h2, 7'h00, 8'h00, 16'h0000);
    chk("tx_send2", 1'b1, tx_send);
    wait_tx();
    chk("state_end", UEC_IDLE, ep0_state);
    tk(2'h1, 7'h00, 8'h00, 16'h0000);
    chk("status_ack", 1'b1, hs_ack);
    $display("test read done");
    // Host asks for more after the last packet: must be stalled
    tk(2'h0, 7'h08, 8'h80, 16'h0050);
    fw(8'h40);
    fw(8'h0a);
    tk(2'h2, 7'h00, 8'h00, 16'h0000);
    wait_tx();
    ack();
    tk(2'h2, 7'h00, 8'h00, 16'h0000);
    chk("in_extra", 3'h7, {hs_stall, stall_sent_flag, ep0_int});
    chk("state_in_extra", UEC_IDLE, ep0_state);
    fw(8'h04);
    $display("test late_in done");
    tk(2'h0, 7'h08, 8'h00, 16'h0046);
    fw(8'h40);
    ack();
    tk(2'h0, 7'h08, 8'h00, 16'h0000);
    chk("early_end", 3'h7, {premature_end_flag, rx_packet_ready, ep0_int});
    fw(8'h80);
    chk("end_clr", 1'b0, premature_end_flag);
    $display("test early_end done");
    end_of_test();
  end
endmodule

`default_nettype wire

/* dv/uec_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Host side: tokens, packets, acks
// ----------------------------------------
module uec_host_model (
  input wire logic core_clk,
  input wire logic tx_send,
  input wire logic [3:0] ack_delay,
  output logic link_setup,
  output logic link_out,
  output logic link_in_token,
  output logic link_tx_done,
  output logic [6:0] link_len,
  output logic [7:0] link_req_type,
  output logic [15:0] link_req_length
);
  initial begin
    {link_setup, link_out, link_in_token, link_tx_done} = 4'h0;
    link_len = 7'h00;
    link_req_type = 8'h00;
    link_req_length = 16'h0000;
  end

  // Kind 0 setup, 1 out, 2 in; released qualifiers inverted, never left valid
  task automatic tok(input logic [1:0] k, input logic [6:0] n, input logic [7:0] rt,
                     input logic [15:0] rl);
    @(negedge core_clk);
    link_setup = (k == 2'h0);
    link_out = (k == 2'h1);
    link_in_token = (k == 2'h2);
    link_len = n;
    link_req_type = rt;
    link_req_length = rl;
    @(negedge core_clk);
    {link_setup, link_out, link_in_token} = 3'h0;
    link_len = ~link_len;
    link_req_type = ~link_req_type;
    link_req_length = ~link_req_length;
  endtask

  // Prompt or slow ack of every packet sent
  always begin
    @(negedge core_clk);
    if (tx_send === 1'b1) begin
      repeat (ack_delay) @(negedge core_clk);
      link_tx_done = 1'b1;
      @(negedge core_clk);
      link_tx_done = 1'b0;
    end
  end
endmodule

`default_nettype wire

/* rtl/uec_ep0_ctrl.sv */
// Operation
// - Received packet sets rx ready, interrupts
// - Status stage raises completion interrupt
// - Stall request stalls next IN or OUT token, flags
// - OUT after data end is stalled
// - Byte count of received packet readable
// - Sent packet clears tx ready, interrupts
// - IN after data end is stalled
// - Three states, idle after reset
// - Decode request, switch FIFO direction
// - Early transfer end sets premature flag
// - Request length picks idle, request type picks rx or tx
// - Serviced bit clears rx ready
// - Setup not eight bytes is rejected
// - End-serviced bit clears premature flag
`timescale 1ns/100ps
`default_nettype none

module uec_ep0_ctrl
  import uec_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic link_setup,
  input wire logic link_out,
  input wire logic [6:0] link_len,
  input wire logic [7:0] link_req_type,
  input wire logic [15:0] link_req_length,
  input wire logic link_in_token,
  input wire logic link_tx_done,
  input wire logic fw_csr_we,
  input wire logic [7:0] fw_csr_wdata,
  input wire logic fw_addr_we,
  input wire logic [6:0] fw_addr,
  input wire logic fw_int_ack,
  input wire logic ep0_int_en,
  output logic rx_packet_ready,
  output logic tx_packet_ready,
  output logic stall_sent_flag,
  output logic premature_end_flag,
  output logic data_phase_end,
  output logic stall_request,
  output logic [6:0] ep0_rx_byte_count,
  output logic [6:0] function_address,
  output logic [2:0] ep0_state,
  output logic fifo_dir_in,
  output logic hs_ack,
  output logic hs_nak,
  output logic hs_stall,
  output logic tx_send,
  output logic tx_zero_len,
  output logic ep0_int
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  uec_state_e st, next_st;
  logic next_rx_packet_ready, next_tx_packet_ready, next_stall_sent_flag;
  logic next_premature_end_flag, next_data_phase_end, next_stall_request;
  logic [6:0] next_ep0_rx_byte_count, next_function_address;
  logic next_fifo_dir_in, next_hs_ack, next_hs_nak, next_hs_stall;
  logic next_tx_send, next_tx_zero_len, next_ep0_int;
  logic status_wait, next_status_wait;
  logic status_in, next_status_in;
  logic req_dir_in, next_req_dir_in;
  logic req_has_data, next_req_has_data;
  logic irq_pend, next_irq_pend;
  logic do_stall, do_prem, do_int;

  function automatic logic wbit(input logic [7:0] d, input int pos);
    return fw_csr_we && d[pos];
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_rx_packet_ready = rx_packet_ready;
    next_tx_packet_ready = tx_packet_ready;
    next_stall_sent_flag = stall_sent_flag;
    next_premature_end_flag = premature_end_flag;
    next_data_phase_end = data_phase_end;
    next_stall_request = stall_request;
    next_ep0_rx_byte_count = ep0_rx_byte_count;
    next_function_address = function_address;
    next_fifo_dir_in = fifo_dir_in;
    next_status_wait = status_wait;
    next_status_in = status_in;
    next_req_dir_in = req_dir_in;
    next_req_has_data = req_has_data;
    next_irq_pend = irq_pend;
    next_hs_ack = 1'b0;
    next_hs_nak = 1'b0;
    next_hs_stall = 1'b0;
    next_tx_send = 1'b0;
    next_tx_zero_len = 1'b0;
    do_stall = 1'b0;
    do_prem = 1'b0;
    do_int = 1'b0;

    // Firmware side first, so link events below win over its clears
    if (fw_addr_we) begin
      next_function_address = fw_addr;
    end
    if (fw_int_ack) begin
      next_irq_pend = 1'b0;
    end
    if (wbit(fw_csr_wdata, UEC_BIT_STALL_CLR)) begin
      next_stall_sent_flag = 1'b0;
    end
    if (wbit(fw_csr_wdata, UEC_BIT_END_SERVICED)) begin
      next_premature_end_flag = 1'b0;
    end
    if (wbit(fw_csr_wdata, UEC_BIT_STALL_REQ)) begin
      next_stall_request = 1'b1;
    end
    if (wbit(fw_csr_wdata, UEC_BIT_TX_READY)) begin
      next_tx_packet_ready = 1'b1;
    end
    if (wbit(fw_csr_wdata, UEC_BIT_DATA_END)) begin
      next_data_phase_end = 1'b1;
    end
    if (wbit(fw_csr_wdata, UEC_BIT_RX_SERVICED)) begin
      next_rx_packet_ready = 1'b0;
      if (st == UEC_IDLE && rx_packet_ready && !status_wait) begin
        if (req_has_data && !fw_csr_wdata[UEC_BIT_DATA_END]) begin
          // Direction flips without firmware help
          next_st = req_dir_in ? UEC_TX : UEC_RX;
          next_fifo_dir_in = req_dir_in;
        end else begin
          next_status_wait = 1'b1;
          next_status_in = 1'b1;
        end
      end else if (st == UEC_RX && fw_csr_wdata[UEC_BIT_DATA_END]) begin
        next_st = UEC_IDLE;
        next_status_wait = 1'b1;
        next_status_in = 1'b1;
      end
    end

    // Link side
    if (link_setup) begin
      if (link_len == UEC_SETUP_LEN) begin
        if (st != UEC_IDLE || status_wait) begin
          do_prem = 1'b1;
        end
        next_st = UEC_IDLE;
        next_status_wait = 1'b0;
        next_data_phase_end = 1'b0;
        next_stall_request = 1'b0;
        next_tx_packet_ready = 1'b0;
        next_fifo_dir_in = 1'b0;
        next_rx_packet_ready = 1'b1;
        next_ep0_rx_byte_count = link_len;
        next_req_dir_in = link_req_type[UEC_BIT_REQ_DIR_IN];
        next_req_has_data = link_req_length != 16'h0000;
        next_hs_ack = 1'b1;
        do_int = 1'b1;
      end
    end else if (link_out) begin
      if (stall_request) begin
        do_stall = 1'b1;
      end else if (status_wait && !status_in) begin
        if (link_len != 7'h00) begin
          do_stall = 1'b1;
        end else begin
          next_hs_ack = 1'b1;
          next_status_wait = 1'b0;
          next_data_phase_end = 1'b0;
          do_int = 1'b1;
        end
      end else if (st == UEC_TX) begin
        do_prem = 1'b1;
      end else if (data_phase_end) begin
        do_stall = 1'b1;
      end else if (st == UEC_RX) begin
        if (link_len > UEC_MAX_PKT) begin
          do_stall = 1'b1;
        end else if (rx_packet_ready && !wbit(fw_csr_wdata, UEC_BIT_RX_SERVICED)) begin
          next_hs_nak = 1'b1; // Previous packet still unread
        end else begin
          next_rx_packet_ready = 1'b1;
          next_ep0_rx_byte_count = link_len;
          next_hs_ack = 1'b1;
          do_int = 1'b1;
        end
      end else begin
        next_hs_nak = 1'b1;
      end
    end else if (link_in_token) begin
      if (stall_request) begin
        do_stall = 1'b1;
      end else if (status_wait && status_in) begin
        next_tx_zero_len = 1'b1;
        next_status_wait = 1'b0;
        next_data_phase_end = 1'b0;
        do_int = 1'b1;
      end else if (st == UEC_RX) begin
        do_prem = 1'b1;
      end else if (st == UEC_TX && tx_packet_ready) begin
        next_tx_send = 1'b1;
      end else if (data_phase_end) begin
        do_stall = 1'b1;
      end else begin
        next_hs_nak = 1'b1;
      end
    end

    if (link_tx_done) begin
      next_tx_packet_ready = 1'b0;
      do_int = 1'b1;
      if (data_phase_end) begin
        next_st = UEC_IDLE;
        next_status_wait = 1'b1;
        next_status_in = 1'b0;
      end
    end

    // Abort paths leave the endpoint in idle
    if (do_stall) begin
      next_hs_stall = 1'b1;
      next_stall_sent_flag = 1'b1;
      next_stall_request = 1'b0;
      next_st = UEC_IDLE;
      next_status_wait = 1'b0;
      next_data_phase_end = 1'b0;
      next_tx_packet_ready = 1'b0;
      do_int = 1'b1;
    end
    if (do_prem) begin
      next_premature_end_flag = 1'b1;
      next_st = UEC_IDLE;
      if (!link_setup) begin
        next_status_wait = 1'b0;
        next_data_phase_end = 1'b0;
        next_tx_packet_ready = 1'b0;
      end
      do_int = 1'b1;
    end
    if (do_int) begin
      next_irq_pend = 1'b1;
    end
    next_ep0_int = next_irq_pend && ep0_int_en;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st <= UEC_IDLE;
      rx_packet_ready <= 1'b0;
      tx_packet_ready <= 1'b0;
      stall_sent_flag <= 1'b0;
      premature_end_flag <= 1'b0;
      data_phase_end <= 1'b0;
      stall_request <= 1'b0;
      ep0_rx_byte_count <= UEC_COUNT_RST;
      function_address <= UEC_ADDR_RST;
      ep0_state <= UEC_IDLE;
      fifo_dir_in <= 1'b0;
      status_wait <= 1'b0;
      status_in <= 1'b0;
      req_dir_in <= 1'b0;
      req_has_data <= 1'b0;
      irq_pend <= 1'b0;
      hs_ack <= 1'b0;
      hs_nak <= 1'b0;
      hs_stall <= 1'b0;
      tx_send <= 1'b0;
      tx_zero_len <= 1'b0;
      ep0_int <= 1'b0;
    end else begin
      st <= next_st;
      rx_packet_ready <= next_rx_packet_ready;
      tx_packet_ready <= next_tx_packet_ready;
      stall_sent_flag <= next_stall_sent_flag;
      premature_end_flag <= next_premature_end_flag;
      data_phase_end <= next_data_phase_end;
      stall_request <= next_stall_request;
      ep0_rx_byte_count <= next_ep0_rx_byte_count;
      function_address <= next_function_address;
      ep0_state <= next_st;
      fifo_dir_in <= next_fifo_dir_in;
      status_wait <= next_status_wait;
      status_in <= next_status_in;
      req_dir_in <= next_req_dir_in;
      req_has_data <= next_req_has_data;
      irq_pend <= next_irq_pend;
      hs_ack <= next_hs_ack;
      hs_nak <= next_hs_nak;
      hs_stall <= next_hs_stall;
      tx_send <= next_tx_send;
      tx_zero_len <= next_tx_zero_len;
      ep0_int <= next_ep0_int;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic fw_quiet;
  assign fw_quiet = !fw_csr_we && !fw_int_ack;

  setup_flag_a: assert property (
    link_setup && link_len == UEC_SETUP_LEN && fw_quiet
    |=> rx_packet_ready && irq_pend ##1 rx_packet_ready || $past(fw_csr_we))
    else $error("setup did not raise rx ready");

  setup_reject_a: assert property (
    link_setup && link_len != UEC_SETUP_LEN && !fw_csr_we && !link_tx_done
    |=> !hs_ack && rx_packet_ready == $past(rx_packet_ready))
    else $error("short setup was accepted");

  stall_answer_a: assert property (
    (link_in_token || link_out) && !link_setup && stall_request
    |=> hs_stall && stall_sent_flag && !stall_request && ep0_state == UEC_IDLE)
    else $error("stall request not answered");

  tx_done_clear_a: assert property (
    link_tx_done && !fw_csr_we && !fw_int_ack |=> !tx_packet_ready && irq_pend)
    else $error("sent packet left tx ready set");

  serviced_clear_a: assert property (
    fw_csr_we && fw_csr_wdata[UEC_BIT_RX_SERVICED] && !link_setup && !link_out
    |=> !rx_packet_ready)
    else $error("serviced bit left rx ready set");

  dir_decode_a: assert property (
    st == UEC_IDLE && rx_packet_ready && !status_wait && req_has_data
    && fw_csr_we && fw_csr_wdata == 8'h40 && !link_setup && !link_out
    && !link_in_token && !link_tx_done
    |=> ep0_state == (req_dir_in ? UEC_TX : UEC_RX) && fifo_dir_in == $past(req_dir_in))
    else $error("data phase direction not taken");

  rx_count_a: assert property (
    link_out && st == UEC_RX && !stall_request && !data_phase_end && !rx_packet_ready
    && link_len <= UEC_MAX_PKT && !link_setup
    |=> ep0_rx_byte_count == $past(link_len) ##1 ep0_rx_byte_count == $past(link_len, 2)
    || $past(link_out) || $past(link_setup))
    else $error("byte count not presented");

  prem_sticky_a: assert property (
    premature_end_flag && !(fw_csr_we && fw_csr_wdata[UEC_BIT_END_SERVICED])
    |=> premature_end_flag)
    else $error("premature end flag lost");

  prem_idle_a: assert property (
    $rose(premature_end_flag) |-> ep0_state == UEC_IDLE && irq_pend)
    else $error("premature end not handled");

  late_out_a: assert property (
    link_out && !link_setup && !stall_request && data_phase_end && status_in && st != UEC_TX
    |=> hs_stall && stall_sent_flag)
    else $error("late OUT not stalled");

  status_done_a: assert property (
    link_in_token && !link_setup && !link_out && !stall_request && status_wait && status_in
    |=> tx_zero_len && irq_pend && !data_phase_end)
    else $error("status stage not confirmed");

endmodule

`default_nettype wire

/* rtl/uec_pkg.sv */
`default_nettype none

package uec_pkg;

  // ------------------------------------------------------------
  // Endpoint 0 states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    UEC_IDLE = 3'h1,
    UEC_TX   = 3'h2,
    UEC_RX   = 3'h4
  } uec_state_e;

  // ------------------------------------------------------------
  // Control/status write and request type field positions
  // ------------------------------------------------------------
  localparam int UEC_BIT_TX_READY = 1;
  localparam int UEC_BIT_STALL_CLR = 2;
  localparam int UEC_BIT_DATA_END = 3;
  localparam int UEC_BIT_STALL_REQ = 5;
  localparam int UEC_BIT_RX_SERVICED = 6;
  localparam int UEC_BIT_END_SERVICED = 7;
  localparam int UEC_BIT_REQ_DIR_IN = 7;

  // ------------------------------------------------------------
  // Sizes and reset values
  // ------------------------------------------------------------
  localparam logic [6:0] UEC_SETUP_LEN = 7'h08;
  localparam logic [6:0] UEC_MAX_PKT = 7'h40;
  localparam logic [6:0] UEC_COUNT_RST = 7'h00;
  localparam logic [6:0] UEC_ADDR_RST = 7'h00;

endpackage

`default_nettype wire
